// ---- rtl/ufp_device.sv ----
// bridge device end: pin handshake, reset output and pin states during reset and suspend
// Summary of operation
// - reset output floats about 5 ms, then high
// - external reset low forces reset output low
// - oscillator output stops while link suspended
// - test select held low in normal use
// - input pins pulled up, optionally low suspended
// - flags float pulled up during reset
// - eeprom pins float pulled up during reset
// - read strobe low at least 50 ns
// - read strobe high 50 ns plus flag gap
// - read data valid 20-50 ns, held after; this block drives it three cycles (120 ns) after the strobe falls
// - write strobe high at least 50 ns
// - write strobe low at least 50 ns
// - tx space flag inactive 80 ns per write
// - drive byte on read low, fetch on rise
// - capture byte on write falling edge
// - transfer only while its flag is low
`include "ufp_defs.svh"
module ufp_device
  import ufp_pkg::*;
#(
  parameter int RST_HIZ_CYC = `UFP_RST_HIZ_CYC
)(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire logic            ext_reset_n,
  // pins
  ufp_if.device                pins,
  // oscillator
  input  wire logic            oscillator_in,
  output logic                 oscillator_out,
  // reset output as two signals
  output logic                 reset_out_n,
  output logic                 reset_out_n_oe,
  // eeprom pins, enables only; values low whenever driven
  output logic                 eeprom_select_oe,
  output logic                 eeprom_clock_oe,
  output logic                 eeprom_io_oe,
  // usb side stream
  input  wire ufp_pkg::ufp_byte_t rx_byte,
  input  wire logic            rx_valid,
  output logic                 rx_ready,
  output ufp_pkg::ufp_byte_t   tx_byte,
  output logic                 tx_valid,
  input  wire logic            tx_ready,
  // link state and options
  input  wire logic            usb_configured,
  input  wire logic            usb_suspend,
  input  wire logic            suspend_pull_down_en
);
  import ufp_pkg::*;

  if (RST_HIZ_CYC < 1) begin : g_bad_hold
    $error("RST_HIZ_CYC must be at least 1");
  end

  localparam logic [`UFP_CNT_W-1:0] TXE_BUSY = `UFP_CNT_W'(`UFP_TXE_BUSY_CYC);

  // pin synchronisers
  logic [1:0] rd_sync;
  logic [1:0] wr_sync;
  logic [1:0] xrst_sync;
  logic [1:0] osc_sync;
  // bus staged beside the write strobe; capture sees it while wr was still high
  ufp_byte_t  bus_sync0;
  ufp_byte_t  bus_sync1;
  ufp_byte_t  bus_q;
  logic       rd_q;
  logic       wr_q;
  logic [31:0] por_cnt;
  ufp_por_t   por_state;
  ufp_byte_t  rx_hold;
  logic       rx_full;
  logic [`UFP_CNT_W-1:0] txe_cnt;
  logic       in_reset;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_sync   <= 2'h3;
      wr_sync   <= 2'h0;
      // idle level, so no false external reset right after release
      xrst_sync <= 2'h3;
      osc_sync  <= 2'h0;
      rd_q      <= 1'b1;
      wr_q      <= 1'b0;
      bus_sync0 <= 8'hff;
      bus_sync1 <= 8'hff;
      bus_q     <= 8'hff;
    end else begin
      rd_sync   <= {rd_sync[0], pins.rd_n};
      wr_sync   <= {wr_sync[0], pins.wr};
      xrst_sync <= {xrst_sync[0], ext_reset_n};
      osc_sync  <= {osc_sync[0], oscillator_in};
      rd_q      <= rd_sync[1];
      wr_q      <= wr_sync[1];
      bus_sync0 <= pins.fifo_data_bus;
      bus_sync1 <= bus_sync0;
      bus_q     <= bus_sync1;
    end
  end

  wire rd_low   = !rd_sync[1];
  wire rd_rise  = rd_sync[1] && !rd_q;
  wire wr_fall  = !wr_sync[1] && wr_q;
  wire xrst_low = !xrst_sync[1];

  // power-on release counter; external reset restarts it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      por_cnt   <= 32'h0;
      por_state <= UFP_POR_HIZ;
    end else begin
      case (por_state)
        UFP_POR_HIZ: begin
          if (xrst_low)
            por_cnt <= 32'h0;
          else if (por_cnt >= 32'(RST_HIZ_CYC - 1))
            por_state <= UFP_POR_DRIVE;
          else
            por_cnt <= por_cnt + 32'h1;
        end
        UFP_POR_DRIVE: begin
          if (xrst_low) begin
            por_state <= UFP_POR_HIZ;
            por_cnt   <= 32'h0;
          end
        end
        default: por_state <= UFP_POR_HIZ;
      endcase
    end
  end

  assign in_reset = (por_state != UFP_POR_DRIVE);

  // receive holding byte: fetched from the stream, consumed on read strobe rise
  wire fetch = !rx_full && rx_valid && rx_ready && !in_reset;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_full <= 1'b0;
      rx_hold <= 8'h00;
    end else if (in_reset) begin
      rx_full <= 1'b0;
    end else if (rd_rise && rx_full) begin
      rx_full <= 1'b0;
    end else if (fetch) begin
      rx_full <= 1'b1;
      rx_hold <= rx_byte;
    end
  end

  // write capture with busy window after each write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_valid <= 1'b0;
      tx_byte  <= 8'h00;
      txe_cnt  <= '0;
    end else begin
      if (tx_valid && tx_ready)
        tx_valid <= 1'b0;
      if (wr_fall && !in_reset && (!tx_valid || tx_ready)) begin
        tx_valid <= 1'b1;
        tx_byte  <= bus_q;
        txe_cnt  <= TXE_BUSY;
      end else if (txe_cnt != '0) begin
        txe_cnt <= txe_cnt - `UFP_CNT_W'(1);
      end
    end
  end

  // registered pin outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pins.data_dev       <= 8'h00;
      pins.data_dev_oe    <= 1'b0;
      pins.tx_space_n     <= 1'b1;
      pins.tx_space_n_oe  <= 1'b0;
      pins.rx_avail_n     <= 1'b1;
      pins.rx_avail_n_oe  <= 1'b0;
      pins.power_enable_n <= 1'b1;
      pins.pull_low       <= 1'b0;
      reset_out_n         <= 1'b0;
      reset_out_n_oe      <= 1'b0;
      eeprom_select_oe    <= 1'b0;
      eeprom_clock_oe     <= 1'b0;
      eeprom_io_oe        <= 1'b0;
      oscillator_out      <= 1'b0;
      rx_ready            <= 1'b0;
    end else begin
      // data driven only while strobe low and a byte is held
      pins.data_dev       <= rx_hold;
      pins.data_dev_oe    <= rd_low && rx_full && !in_reset;
      // flags float during reset; pull-ups give inactive high
      pins.tx_space_n_oe  <= !in_reset;
      pins.rx_avail_n_oe  <= !in_reset;
      pins.tx_space_n     <= tx_valid || (txe_cnt != '0) || wr_fall;
      pins.rx_avail_n     <= !rx_full || rd_rise;
      pins.power_enable_n <= !usb_configured || usb_suspend;
      pins.pull_low       <= suspend_pull_down_en && usb_suspend;
      // external reset drives low, else float until release, then high
      reset_out_n         <= !xrst_low && !in_reset;
      reset_out_n_oe      <= xrst_low || !in_reset;
      // eeprom pins released to pull-ups in reset; the loader is not part of this block
      eeprom_select_oe    <= 1'b0;
      eeprom_clock_oe     <= 1'b0;
      eeprom_io_oe        <= 1'b0;
      oscillator_out      <= osc_sync[1] && !usb_suspend;
      rx_ready            <= !rx_full && !in_reset && !fetch;
    end
  end
endmodule

// ---- rtl/ufp_defs.svh ----
// timing and reset constants for the usb fifo parallel port
`ifndef UFP_DEFS_SVH
`define UFP_DEFS_SVH
`define UFP_CLK_NS        40
`define UFP_RST_HIZ_NS    5000000
`define UFP_RD_PULSE_NS   50
`define UFP_RD_GAP_NS     50
`define UFP_RD_DATA_NS    50
`define UFP_WR_PULSE_NS   50
`define UFP_WR_GAP_NS     50
`define UFP_TXE_BUSY_NS   80
// least times round up, never below one cycle
`define UFP_CYC_UP(ns)    ((((ns) + `UFP_CLK_NS - 1) / `UFP_CLK_NS) < 1 ? 1 : (((ns) + `UFP_CLK_NS - 1) / `UFP_CLK_NS))
`define UFP_RST_HIZ_CYC   (`UFP_CYC_UP(`UFP_RST_HIZ_NS))
`define UFP_RD_PULSE_CYC  (`UFP_CYC_UP(`UFP_RD_PULSE_NS))
`define UFP_RD_GAP_CYC    (`UFP_CYC_UP(`UFP_RD_GAP_NS))
`define UFP_WR_PULSE_CYC  (`UFP_CYC_UP(`UFP_WR_PULSE_NS))
`define UFP_WR_GAP_CYC    (`UFP_CYC_UP(`UFP_WR_GAP_NS))
`define UFP_TXE_BUSY_CYC  (`UFP_CYC_UP(`UFP_TXE_BUSY_NS))
`define UFP_CNT_W         8
`define UFP_DATA_W        8
// extra strobe cycles so the far end's two-stage synchronisers see each level
`define UFP_SYNC_MARGIN   3
`define UFP_STROBE_MAX    250
`endif

// ---- rtl/ufp_pkg.sv ----
// shared types of the usb fifo parallel port
package ufp_pkg;
  typedef logic [7:0] ufp_byte_t;
  typedef enum logic [1:0] {UFP_POR_HIZ, UFP_POR_DRIVE} ufp_por_t;
endpackage

// ---- rtl/ufp_if.sv ----
// pin-level carrier between the bridge device and the external logic
interface ufp_if;
  import ufp_pkg::*;
  ufp_byte_t data_dev;
  logic      data_dev_oe;
  ufp_byte_t data_host;
  logic      data_host_oe;
  ufp_byte_t fifo_data_bus;
  logic      rd_n;
  logic      wr;
  logic      tx_space_n;
  logic      tx_space_n_oe;
  logic      rx_avail_n;
  logic      rx_avail_n_oe;
  logic      power_enable_n;
  logic      pull_low;
  ufp_byte_t data_pull;
  logic      tx_space_pin;
  logic      rx_avail_pin;
  // weak pull-up on the data bus, or gently low when the pull-down option is on in suspend
  assign data_pull     = pull_low ? 8'h00 : 8'hff;
  assign fifo_data_bus = data_dev_oe ? data_dev : (data_host_oe ? data_host : data_pull);
  assign tx_space_pin  = tx_space_n_oe ? tx_space_n : 1'b1;
  assign rx_avail_pin  = rx_avail_n_oe ? rx_avail_n : 1'b1;
  modport device (input fifo_data_bus, input rd_n, input wr,
                  output data_dev, output data_dev_oe, output tx_space_n, output tx_space_n_oe,
                  output rx_avail_n, output rx_avail_n_oe, output power_enable_n, output pull_low);
  modport host (input fifo_data_bus, input tx_space_pin, input rx_avail_pin, input power_enable_n,
                output data_host, output data_host_oe, output rd_n, output wr);
endinterface

// ---- rtl/ufp_host.sv ----
// external logic end: synchronised flags, timed read and write strobes
`include "ufp_defs.svh"
module ufp_host
  import ufp_pkg::*;
#(
  parameter int PULSE_CYC = `UFP_RD_PULSE_CYC,
  parameter int GAP_CYC   = `UFP_RD_GAP_CYC
)(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst_b,
  // pins
  ufp_if.host                  pins,
  // user requests
  input  wire logic            rd_req,
  output logic                 rd_done,
  output ufp_pkg::ufp_byte_t   rd_data,
  input  wire logic            wr_req,
  input  wire ufp_pkg::ufp_byte_t wr_data,
  output logic                 wr_done,
  output logic                 test_mode
);
  import ufp_pkg::*;

  if (PULSE_CYC < 1 || GAP_CYC < 1 || PULSE_CYC > `UFP_STROBE_MAX || GAP_CYC > `UFP_STROBE_MAX) begin : g_bad_strobe
    $error("strobe counts out of range");
  end

  typedef enum logic [2:0] {UFP_H_IDLE, UFP_H_RD, UFP_H_WR, UFP_H_GAP} ufp_hstate_t;

  logic [1:0]  txe_sync;
  logic [1:0]  rxf_sync;
  ufp_byte_t   bus_sync0;
  ufp_byte_t   bus_sync1;
  ufp_hstate_t state;
  logic [7:0]  cnt;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txe_sync  <= 2'h3;
      rxf_sync  <= 2'h3;
      bus_sync0 <= 8'hff;
      bus_sync1 <= 8'hff;
    end else begin
      txe_sync  <= {txe_sync[0], pins.tx_space_pin};
      rxf_sync  <= {rxf_sync[0], pins.rx_avail_pin};
      bus_sync0 <= pins.fifo_data_bus;
      bus_sync1 <= bus_sync0;
    end
  end

  wire can_rd   = rd_req && !rxf_sync[1];
  wire can_wr   = wr_req && !txe_sync[1];
  wire cnt_done = (cnt == 8'h00);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state             <= UFP_H_IDLE;
      cnt               <= 8'h00;
      pins.rd_n         <= 1'b1;
      pins.wr           <= 1'b0;
      pins.data_host    <= 8'h00;
      pins.data_host_oe <= 1'b0;
      rd_done           <= 1'b0;
      rd_data           <= 8'h00;
      wr_done           <= 1'b0;
      test_mode         <= 1'b0;
    end else begin
      rd_done   <= 1'b0;
      wr_done   <= 1'b0;
      test_mode <= 1'b0;
      case (state)
        UFP_H_IDLE: begin
          if (can_rd) begin
            pins.rd_n <= 1'b0;
            cnt       <= 8'(PULSE_CYC + `UFP_SYNC_MARGIN);
            state     <= UFP_H_RD;
          end else if (can_wr) begin
            pins.wr           <= 1'b1;
            pins.data_host    <= wr_data;
            pins.data_host_oe <= 1'b1;
            cnt               <= 8'(PULSE_CYC);
            state             <= UFP_H_WR;
          end
        end
        UFP_H_RD: begin
          if (cnt_done) begin
            rd_data   <= bus_sync1;
            pins.rd_n <= 1'b1;
            rd_done   <= 1'b1;
            cnt       <= 8'(GAP_CYC + `UFP_SYNC_MARGIN);
            state     <= UFP_H_GAP;
          end else
            cnt <= cnt - 8'h01;
        end
        UFP_H_WR: begin
          if (cnt_done) begin
            pins.wr <= 1'b0;
            wr_done <= 1'b1;
            cnt     <= 8'(GAP_CYC + `UFP_SYNC_MARGIN);
            state   <= UFP_H_GAP;
          end else
            cnt <= cnt - 8'h01;
        end
        UFP_H_GAP: begin
          pins.data_host_oe <= 1'b0;
          if (cnt_done)
            state <= UFP_H_IDLE;
          else
            cnt <= cnt - 8'h01;
        end
        default: state <= UFP_H_IDLE;
      endcase
    end
  end
endmodule

// ---- test/ufp_checker.sv ----
// pin-level assertions on the port between device and external logic
module ufp_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // strobes and bus drives
  input wire logic rd_n,
  input wire logic wr,
  input wire logic data_dev_oe,
  input wire logic data_host_oe,
  // flags and suspend
  input wire logic tx_space_pin,
  input wire logic rx_avail_pin,
  input wire logic power_enable_n,
  input wire logic pull_low
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence rd_low;
    !rd_n [*2];
  endsequence
  sequence wr_high;
    wr [*2];
  endsequence
  // 80 ns is two cycles at this clock
  sequence space_busy;
    tx_space_pin [*2];
  endsequence

  rd_pulse_a: assert property ($fell(rd_n) |-> rd_low) else $error("read strobe too short");
  rd_gap_a: assert property ($rose(rd_n) |-> rd_n [*2]) else $error("read gap too short");
  wr_pulse_a: assert property ($rose(wr) |-> wr_high) else $error("write strobe too short");
  wr_gap_a: assert property ($fell(wr) |-> !wr [*2]) else $error("write gap too short");
  space_busy_a: assert property ($fell(wr) |-> ##[1:5] space_busy) else $error("space flag not held");
  wr_space_a: assert property (tx_space_pin [*4] |=> !$rose(wr)) else $error("write without space");
  rd_avail_a: assert property (rx_avail_pin [*4] |=> !$fell(rd_n)) else $error("read without data");
  rd_drive_a: assert property ($fell(rd_n) |-> ##[1:5] data_dev_oe) else $error("read byte not driven");
  rd_release_a: assert property ($rose(rd_n) |-> ##[1:5] !data_dev_oe) else $error("bus not released");
  bus_share_a: assert property (!(data_dev_oe && data_host_oe)) else $error("bus driven twice");
  pull_susp_a: assert property (pull_low |-> power_enable_n) else $error("pull low outside suspend");
endmodule

// ---- test/tb_top.sv ----
// self-checking bench: device and external logic joined over the pin carrier
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ufp_pkg::*;
  // short power-on hold keeps the run brief
  localparam int HOLD = 20;
  logic      clk = 1'b0, rst_b = 1'b0, ext_reset_n = 1'b1, osc_in = 1'b0;
  logic      osc_out, rso, rso_oe, ee_cs, ee_ck, ee_io, rx_ready, tx_valid;
  logic      rd_done, wr_done, test_mode;
  logic      rx_valid = 1'b0, tx_ready = 1'b0, susp = 1'b0, pd_en = 1'b0;
  logic      rd_req = 1'b0, wr_req = 1'b0;
  ufp_byte_t rx_byte = 8'h00, wr_data = 8'h00;
  ufp_byte_t tx_byte, rd_data;
  int        bad_count = 0;
  int        tests_run = 0;

  ufp_if u_if ();
  ufp_device #(.RST_HIZ_CYC(HOLD)) u_ufp_device (
    .clk, .rst_b, .ext_reset_n, .pins(u_if), .oscillator_in(osc_in), .oscillator_out(osc_out),
    .reset_out_n(rso), .reset_out_n_oe(rso_oe), .eeprom_select_oe(ee_cs), .eeprom_clock_oe(ee_ck),
    .eeprom_io_oe(ee_io), .rx_byte, .rx_valid, .rx_ready, .tx_byte, .tx_valid, .tx_ready,
    .usb_configured(1'b1), .usb_suspend(susp), .suspend_pull_down_en(pd_en));
  ufp_host u_ufp_host (.clk, .rst_b, .pins(u_if), .rd_req, .rd_done, .rd_data, .wr_req, .wr_data,
    .wr_done, .test_mode);
  ufp_checker u_ufp_checker (.clk, .rst_b, .rd_n(u_if.rd_n), .wr(u_if.wr),
    .data_dev_oe(u_if.data_dev_oe), .data_host_oe(u_if.data_host_oe), .tx_space_pin(u_if.tx_space_pin),
    .rx_avail_pin(u_if.rx_avail_pin), .power_enable_n(u_if.power_enable_n), .pull_low(u_if.pull_low));

  always #20 clk = ~clk;
  always @(negedge clk) osc_in <= ~osc_in;

  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic t_power_on();
    cyc(12);
    check("flags in reset", 8'h03, {u_if.tx_space_pin, u_if.rx_avail_pin});
    check("eeprom drives", 8'h00, {ee_cs, ee_ck, ee_io});
    rst_b = 1'b1;
    cyc(3);
    check("reset out float", 8'h00, rso_oe);
    check("test select", 8'h00, test_mode);
    cyc(HOLD + 6);
    check("reset out high", 8'h03, {rso, rso_oe});
  endtask

  task automatic t_ext_reset();
    ext_reset_n = 1'b0;
    cyc(5);
    check("reset out low", 8'h01, {rso, rso_oe});
    ext_reset_n = 1'b1;
    cyc(HOLD + 8);
    check("reset out back", 8'h03, {rso, rso_oe});
  endtask

  // second byte waits behind a stalled usb side
  task automatic t_write(ufp_byte_t a, ufp_byte_t b);
    int n;
    int early;
    early = 0;
    wr_data = a;
    wr_req = 1'b1;
    for (n = 0; n < 40 && wr_done !== 1'b1; n++) cyc(1);
    wr_data = b;
    for (n = 0; n < 40 && tx_valid !== 1'b1; n++) cyc(1);
    check("tx byte a", a, tx_byte);
    check("space busy", 8'h01, u_if.tx_space_pin);
    for (n = 0; n < 12; n++) begin
      cyc(1);
      if (wr_done === 1'b1) early++;
    end
    check("write in stall", 8'h00, early[7:0]);
    tx_ready = 1'b1;
    cyc(1);
    tx_ready = 1'b0;
    for (n = 0; n < 40 && wr_done !== 1'b1; n++) cyc(1);
    wr_req = 1'b0;
    for (n = 0; n < 40 && tx_valid !== 1'b1; n++) cyc(1);
    check("tx byte b", b, tx_byte);
    tx_ready = 1'b1;
    cyc(1);
    tx_ready = 1'b0;
  endtask

  task automatic t_read(ufp_byte_t d);
    int n;
    check("rx empty", 8'h01, u_if.rx_avail_pin);
    rx_byte = d;
    rx_valid = 1'b1;
    for (n = 0; n < 40 && rx_ready !== 1'b1; n++) cyc(1);
    cyc(1);
    rx_valid = 1'b0;
    rd_req = 1'b1;
    for (n = 0; n < 40 && rd_done !== 1'b1; n++) cyc(1);
    rd_req = 1'b0;
    check("read byte", d, rd_data);
    cyc(8);
    check("rx drained", 8'h01, u_if.rx_avail_pin);
  endtask

  task automatic t_suspend();
    int n;
    int moves;
    logic last;
    moves = 0;
    susp = 1'b1;
    pd_en = 1'b1;
    cyc(6);
    check("power enable", 8'h01, u_if.power_enable_n);
    check("bus pulled low", 8'h00, u_if.fifo_data_bus);
    last = osc_out;
    for (n = 0; n < 8; n++) begin
      cyc(1);
      if (osc_out !== last) moves++;
    end
    check("osc stopped", 8'h00, moves[7:0]);
    susp = 1'b0;
    cyc(6);
    check("bus pulled up", 8'hff, u_if.fifo_data_bus);
    check("power enable run", 8'h00, u_if.power_enable_n);
    moves = 0;
    last = osc_out;
    for (n = 0; n < 8; n++) begin
      cyc(1);
      if (osc_out !== last) moves++;
      last = osc_out;
    end
    check("osc runs", 8'h08, moves[7:0]);
  endtask

  initial begin
    t_power_on();
    t_ext_reset();
    t_write(8'ha5, 8'h5a);
    t_read(8'h3c);
    t_read(8'hc3);
    t_suspend();
    end_of_test();
  end

  // whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
endmodule
